// ---- rtl/emb_monitor.sv ----
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "emb_regs.svh"
module emb_monitor #(
    parameter int unsigned CLK_KHZ = `EMB_CLK_KHZ
) (
    // Clock and reset.
    input  wire logic                clk,
    input  wire logic                rst,
    // Error conditions and environment, synchronous to clk.
    input  wire emb_pkg::emb_err_type err_cond,
    input  wire logic [15:0]         env_value [`EMB_NENV],
    input  wire logic [15:0]         setpoint,
    // Boot self-test results, synchronous to clk.
    input  wire logic                watchdog_ok,
    input  wire logic                watchdog_tripped,
    input  wire logic [15:0]         boot_sum,
    input  wire logic [15:0]         boot_sum_ref,
    input  wire logic [15:0]         prog_sum,
    input  wire logic [15:0]         prog_sum_ref,
    // External clear switch pin.
    input  wire logic                error_clear_switch,
    // Serial tool side.
    input  wire logic [15:0]         tool_id,
    input  wire logic                tool_id_valid,
    // Register port.
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic [31:0]              reg_rdata,
    // Indicators.
    output logic                     any_error_indicator,
    output logic                     fatal_error_indicator,
    output logic                     error_lamp,
    output logic                     system_run,
    output logic                     serial_accept,
    output logic                     program_checksum_fault,
    output logic                     watchdog_trip_fault
);
    import emb_pkg::*;
    localparam int unsigned DROP_CYC  = `EMB_ALARM_DROP_MS * CLK_KHZ;
    localparam int unsigned BOOT_CYC  = `EMB_BOOT_MS * CLK_KHZ;
    localparam int unsigned ON_CYC    = `EMB_FLASH_ON_MS * CLK_KHZ;
    localparam int unsigned GAP_CYC   = `EMB_FLASH_GAP_MS * CLK_KHZ;
    localparam int unsigned SEC_CYC   = `EMB_SECOND_MS * CLK_KHZ;
    // Switch pin synchroniser.
    logic sw_s1_q;
    logic sw_s2_q;
    logic sw_s3_q;
    always_ff @(posedge clk) begin
        sw_s1_q <= error_clear_switch;
        sw_s2_q <= sw_s1_q;
        sw_s3_q <= sw_s2_q;
    end

    // Control and configuration registers.
    logic        new_pulse_q;
    logic        clr_pulse_q;
    logic        inhibit_q;
    logic        sw_en_q;
    logic        blocked_q;
    emb_err_type fatal_mask_q;
    emb_err_type auto_mask_q;
    logic [3:0]  env_sel_q;
    logic [15:0] tool_id_q;
    logic [15:0] last_id_q;
    emb_boot_type state_q;
    wire running   = (state_q == EMB_RUN);
    wire wr_ok     = reg_wr && running;
    wire wr_ctrl   = wr_ok && (reg_addr == `EMB_REG_CTRL);
    wire clr_err   = wr_ctrl && reg_wdata[`EMB_CTRL_CLR_ERR];
    wire clr_hist  = wr_ctrl && reg_wdata[`EMB_CTRL_CLR_HIST];
    wire save_cmd  = wr_ctrl && reg_wdata[`EMB_CTRL_SAVE];
    wire sw_clear  = sw_en_q && sw_s2_q && !sw_s3_q;
    // Configuration writes; inhibit is volatile and resets to zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            new_pulse_q  <= 1'b0;
            clr_pulse_q  <= 1'b0;
            inhibit_q    <= 1'b0;
            sw_en_q      <= 1'b0;
            fatal_mask_q <= 16'h0000;
            auto_mask_q  <= 16'h0000;
            env_sel_q    <= 4'h0;
        end else if (wr_ok) begin
            if (reg_addr == `EMB_REG_CTRL) begin
                new_pulse_q <= reg_wdata[`EMB_CTRL_NEW_PULSE];
                clr_pulse_q <= reg_wdata[`EMB_CTRL_CLR_PULSE];
                inhibit_q   <= reg_wdata[`EMB_CTRL_INHIBIT];
                sw_en_q     <= reg_wdata[`EMB_CTRL_SW_CLEAR_EN];
            end
            if (reg_addr == `EMB_REG_FATAL_MASK) fatal_mask_q <= reg_wdata[15:0];
            if (reg_addr == `EMB_REG_AUTO_MASK) auto_mask_q <= reg_wdata[15:0];
            if (reg_addr == `EMB_REG_ENV_SEL) env_sel_q <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst)
            blocked_q <= 1'b0;
        else if (clr_hist && inhibit_q)
            blocked_q <= 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tool_id_q <= 16'h0000;
            last_id_q <= 16'h0000;
        end else begin
            if (tool_id_valid && running)
                tool_id_q <= tool_id;
            if (save_cmd)
                last_id_q <= tool_id_q;
        end
    end

    // Live flags: set wins over clear, auto flags follow their cause.
    emb_err_type live_q;
    emb_err_type live_d;
    emb_err_type rise_w;
    always_comb begin
        live_d = live_q;
        if (clr_err || sw_clear)
            live_d = 16'h0000;
        live_d = live_d & ~(auto_mask_q & ~err_cond);
        live_d = live_d | err_cond;
    end
    assign rise_w = live_d & ~live_q;

    always_ff @(posedge clk) begin
        if (rst || !running)
            live_q <= 16'h0000;
        else
            live_q <= live_d;
    end

    // Alarm drop timer for new and cleared errors.
    logic [31:0] drop_q;
    wire any_rise  = |rise_w;
    wire any_fall  = |(live_q & ~live_d);
    wire drop_go   = running && new_pulse_q && (any_rise || (clr_pulse_q && any_fall));
    always_ff @(posedge clk) begin
        if (rst)
            drop_q <= 32'h00000000;
        else if (drop_go)
            drop_q <= DROP_CYC;
        else if (drop_q != 32'h00000000)
            drop_q <= drop_q - 32'h00000001;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            any_error_indicator   <= 1'b0;
            fatal_error_indicator <= 1'b0;
        end else begin
            any_error_indicator   <= (|live_d) && !drop_go && (drop_q <= 32'h00000001);
            fatal_error_indicator <= |(live_d & fatal_mask_q);
        end
    end

    logic [31:0] sec_tick_q;
    logic [31:0] seconds_q;
    logic [31:0] hours_q;
    wire  tick = (sec_tick_q == SEC_CYC - 1);
    always_ff @(posedge clk) begin
        if (rst) begin
            sec_tick_q <= 32'h00000000;
            seconds_q  <= 32'h00000000;
            hours_q    <= 32'h00000000;
        end else if (running && setpoint != 16'h0000) begin
            sec_tick_q <= tick ? 32'h00000000 : sec_tick_q + 32'h00000001;
            if (tick) begin
                if (seconds_q == `EMB_SECS_PER_HOUR - 1) begin
                    seconds_q <= 32'h00000000;
                    hours_q   <= hours_q + 32'h00000001;
                end else begin
                    seconds_q <= seconds_q + 32'h00000001;
                end
            end
        end
    end

    // History: counter, first and last time, environment per error.
    logic [15:0] hist_cnt_q  [`EMB_NERR];
    logic [31:0] hist_first_q[`EMB_NERR];
    logic [31:0] hist_last_q [`EMB_NERR];
    logic [15:0] hist_env_q  [`EMB_NERR][`EMB_NENV];
    wire  rec_ok = running && !blocked_q;
    genvar gi;
    for (gi = 0; gi < `EMB_NERR; gi++) begin : g_hist
        always_ff @(posedge clk) begin
            if (clr_hist) begin
                hist_cnt_q[gi]   <= 16'h0000;
                hist_first_q[gi] <= 32'h00000000;
                hist_last_q[gi]  <= 32'h00000000;
                for (int e = 0; e < `EMB_NENV; e++)
                    hist_env_q[gi][e] <= 16'h0000;
            end else if (rec_ok && rise_w[gi]) begin
                if (hist_cnt_q[gi] != 16'hFFFF)
                    hist_cnt_q[gi] <= hist_cnt_q[gi] + 16'h0001;
                if (hist_cnt_q[gi] == 16'h0000)
                    hist_first_q[gi] <= hours_q;
                hist_last_q[gi] <= hours_q;
                for (int e = 0; e < `EMB_NENV; e++)
                    hist_env_q[gi][e] <= env_value[e];
            end
        end
    end
    // Boot sequencer with RAM self test.
    logic [15:0] ram_mem [`EMB_RAM_WORDS];
    logic [5:0]  ram_idx_q;
    logic        ram_pass_q;
    logic [31:0] boot_cnt_q;
    wire [15:0]  ram_pat = ram_pass_q ? `EMB_RAM_PAT_B : `EMB_RAM_PAT_A;
    wire         ram_last = (ram_idx_q == 6'(`EMB_RAM_WORDS - 1));
    logic        prog_fault_q;
    logic        wd_fault_q;

    always_ff @(posedge clk) begin
        if (state_q == EMB_RAM_WR)
            ram_mem[ram_idx_q] <= ram_pat;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q      <= EMB_WDOG;
            ram_idx_q    <= 6'h00;
            ram_pass_q   <= 1'b0;
            boot_cnt_q   <= 32'h00000000;
            prog_fault_q <= 1'b0;
            wd_fault_q   <= 1'b0;
        end else begin
            boot_cnt_q <= boot_cnt_q + 32'h00000001;
            case (state_q)
                EMB_WDOG: begin
                    if (watchdog_tripped) begin
                        wd_fault_q <= 1'b1;
                        state_q    <= EMB_HALT;
                    end else begin
                        state_q <= watchdog_ok ? EMB_RAM_WR : EMB_HALT;
                    end
                end
                EMB_RAM_WR: begin
                    ram_idx_q <= ram_idx_q + 6'h01;
                    if (ram_last)
                        state_q <= EMB_RAM_RD;
                end
                EMB_RAM_RD: begin
                    ram_idx_q <= ram_idx_q + 6'h01;
                    if (ram_mem[ram_idx_q] != ram_pat)
                        state_q <= EMB_HALT;
                    else if (ram_last) begin
                        ram_pass_q <= 1'b1;
                        state_q    <= ram_pass_q ? EMB_BOOT_SUM : EMB_RAM_WR;
                    end
                end
                EMB_BOOT_SUM:
                    state_q <= (boot_sum == boot_sum_ref) ? EMB_PROG_SUM : EMB_HALT;
                EMB_PROG_SUM: begin
                    if (prog_sum != prog_sum_ref) begin
                        prog_fault_q <= 1'b1;
                        state_q      <= EMB_HALT;
                    end else begin
                        state_q <= EMB_INIT;
                    end
                end
                EMB_INIT: begin
                    if (boot_cnt_q >= BOOT_CYC - 1)
                        state_q <= EMB_RUN;
                end
                EMB_RUN, EMB_HALT: state_q <= state_q;
                default:  state_q <= EMB_HALT;
            endcase
        end
    end

    // Lamp flash pattern: three short pulses then a long gap.
    logic [31:0] fl_cnt_q;
    logic [2:0]  fl_ph_q;
    wire flashing = (state_q == EMB_HALT) && (prog_fault_q || wd_fault_q);
    wire fl_end   = (fl_ph_q == 3'd5) ? (fl_cnt_q >= GAP_CYC - 1) : (fl_cnt_q >= ON_CYC - 1);
    always_ff @(posedge clk) begin
        if (rst || !flashing) begin
            fl_cnt_q <= 32'h00000000;
            fl_ph_q  <= 3'h0;
        end else if (fl_end) begin
            fl_cnt_q <= 32'h00000000;
            fl_ph_q  <= (fl_ph_q == 3'd5) ? 3'h0 : fl_ph_q + 3'h1;
        end else begin
            fl_cnt_q <= fl_cnt_q + 32'h00000001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            error_lamp             <= 1'b0;
            system_run             <= 1'b0;
            serial_accept          <= 1'b0;
            program_checksum_fault <= 1'b0;
            watchdog_trip_fault    <= 1'b0;
        end else begin
            error_lamp             <= flashing ? (fl_ph_q != 3'd5 && !fl_ph_q[0])
                                               : (state_q == EMB_HALT);
            system_run             <= running;
            serial_accept          <= running || flashing;
            program_checksum_fault <= prog_fault_q;
            watchdog_trip_fault    <= wd_fault_q;
        end
    end
    wire       hist_hit = (reg_addr >= `EMB_REG_HIST_BASE) && (reg_addr <= `EMB_REG_HIST_END);
    wire [3:0] hsel     = 4'(reg_addr - `EMB_REG_HIST_BASE);
    logic [31:0] rd_mux;
    always_comb begin
        case (reg_addr)
            `EMB_REG_CTRL:       rd_mux = {28'h0, sw_en_q, inhibit_q, clr_pulse_q, new_pulse_q};
            `EMB_REG_STATUS:     rd_mux = {24'h0, blocked_q, wd_fault_q, prog_fault_q,
                                           2'b00, 3'(state_q)};
            `EMB_REG_LIVE:       rd_mux = {16'h0, live_q};
            `EMB_REG_FATAL_MASK: rd_mux = {16'h0, fatal_mask_q};
            `EMB_REG_AUTO_MASK:  rd_mux = {16'h0, auto_mask_q};
            `EMB_REG_HOURS:      rd_mux = hours_q;
            `EMB_REG_SECONDS:    rd_mux = seconds_q;
            `EMB_REG_TOOL_ID:    rd_mux = {16'h0, tool_id_q};
            `EMB_REG_LAST_ID:    rd_mux = {16'h0, last_id_q};
            `EMB_REG_ENV_SEL:    rd_mux = {28'h0, env_sel_q};
            default: begin
                if (hist_hit) begin
                    case (env_sel_q)
                        4'h0:    rd_mux = {16'h0, hist_cnt_q[hsel]};
                        4'h1:    rd_mux = hist_first_q[hsel];
                        4'h2:    rd_mux = hist_last_q[hsel];
                        4'h3:    rd_mux = {16'h0, hist_env_q[hsel][0]};
                        4'h4:    rd_mux = {16'h0, hist_env_q[hsel][1]};
                        4'h5:    rd_mux = {16'h0, hist_env_q[hsel][2]};
                        4'h6:    rd_mux = {16'h0, hist_env_q[hsel][3]};
                        default: rd_mux = 32'h00000000;
                    endcase
                end else begin
                    rd_mux = 32'h00000000;
                end
            end
        endcase
    end
    // Read data registered one cycle after the strobe.
    always_ff @(posedge clk) begin
        if (rst)
            reg_rdata <= 32'h00000000;
        else
            reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end
endmodule : emb_monitor
`default_nettype wire

// ---- rtl/emb_regs.svh ----
`ifndef EMB_REGS_SVH
`define EMB_REGS_SVH
// Clock rate in kHz (200 MHz system clock).
`define EMB_CLK_KHZ          200000
// Common alarm drop time in ms, and its length in cycles (longest time rounds down).
`define EMB_ALARM_DROP_MS    500
`define EMB_ALARM_DROP_CYC   (`EMB_ALARM_DROP_MS * `EMB_CLK_KHZ)
// Total boot and initialisation budget in ms, and its length in cycles.
`define EMB_BOOT_MS          200
`define EMB_BOOT_CYC         (`EMB_BOOT_MS * `EMB_CLK_KHZ)
// Lamp flash timing in ms: short on, short off, long off.
`define EMB_FLASH_ON_MS      200
`define EMB_FLASH_GAP_MS     1000
`define EMB_FLASH_ON_CYC     (`EMB_FLASH_ON_MS * `EMB_CLK_KHZ)
`define EMB_FLASH_GAP_CYC    (`EMB_FLASH_GAP_MS * `EMB_CLK_KHZ)
// One second of run time in ms and in cycles.
`define EMB_SECOND_MS        1000
`define EMB_SECOND_CYC       (`EMB_SECOND_MS * `EMB_CLK_KHZ)
`define EMB_SECS_PER_HOUR    3600
// Offset between live and historic error indices.
`define EMB_HIST_OFFSET      100
// Number of monitored errors and environment values per error.
`define EMB_NERR             16
`define EMB_NENV             4
// RAM test size and patterns.
`define EMB_RAM_WORDS        64
`define EMB_RAM_PAT_A        16'h55AA
`define EMB_RAM_PAT_B        16'hAA55
// Register offsets for the plain register port (word index).
`define EMB_REG_CTRL         8'h00
`define EMB_REG_STATUS       8'h01
`define EMB_REG_LIVE         8'h02
`define EMB_REG_FATAL_MASK   8'h03
`define EMB_REG_AUTO_MASK    8'h04
`define EMB_REG_HOURS        8'h05
`define EMB_REG_SECONDS      8'h06
`define EMB_REG_TOOL_ID      8'h07
`define EMB_REG_LAST_ID      8'h08
`define EMB_REG_ENV_SEL      8'h09
`define EMB_REG_HIST_BASE    8'h10
`define EMB_REG_HIST_END     8'h1F
// Control register bit positions.
`define EMB_CTRL_NEW_PULSE   0
`define EMB_CTRL_CLR_PULSE   1
`define EMB_CTRL_INHIBIT     2
`define EMB_CTRL_SW_CLEAR_EN 3
`define EMB_CTRL_CLR_ERR     4
`define EMB_CTRL_CLR_HIST    5
`define EMB_CTRL_SAVE        6
`endif

// ---- rtl/emb_pkg.sv ----
package emb_pkg;
    typedef enum logic [2:0] {
        EMB_WDOG, EMB_RAM_WR, EMB_RAM_RD, EMB_BOOT_SUM, EMB_PROG_SUM,
        EMB_INIT, EMB_RUN, EMB_HALT
    } emb_boot_type;
    typedef logic [15:0] emb_err_type;
endpackage : emb_pkg

// ---- sim/emb_fast_cfg.sv ----
`default_nettype none
// The simulation count base is set through the clock-rate parameter of the monitor.
`default_nettype wire

// ---- sim/emb_tool_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module emb_tool_model (
    // Clock and device status.
    input  wire logic       clk,
    input  wire logic       serial_accept,
    // Identifier lines toward the device.
    output var logic [15:0] tool_id,
    output var logic        tool_id_valid
);
    // The lines start idle.
    initial begin
        tool_id = 16'h0000;
        tool_id_valid = 1'b0;
    end
    // waits, then sends.
    // The tool stays silent until the device listens; released lines show a dead value.
    task automatic send_id(input logic [15:0] id);
        while (serial_accept !== 1'b1) @(posedge clk);
        tool_id <= id;
        tool_id_valid <= 1'b1;
        @(posedge clk);
        tool_id <= ~id;
        tool_id_valid <= 1'b0;
        @(posedge clk);
    endtask : send_id
endmodule : emb_tool_model
`default_nettype wire

// ---- sim/emb_check_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "emb_regs.svh"
module emb_check_monitor #(
    parameter int CLK_KHZ = `EMB_CLK_KHZ
) (
    // Clock and reset.
    input wire logic                 clk,
    input wire logic                 rst,
    // Error inputs and register read port.
    input wire emb_pkg::emb_err_type err_cond,
    input wire logic [7:0]           reg_addr,
    input wire logic                 reg_rd,
    input wire logic [31:0]          reg_rdata,
    // Status outputs.
    input wire logic                 error_lamp,
    input wire logic                 system_run,
    input wire logic                 serial_accept,
    input wire logic                 program_checksum_fault,
    input wire logic                 watchdog_trip_fault
);
    import emb_pkg::*;
    localparam int OnMax = `EMB_FLASH_ON_MS * CLK_KHZ + 1;
    localparam int GapMax = (`EMB_FLASH_ON_MS + `EMB_FLASH_GAP_MS) * CLK_KHZ + 1;
    logic [31:0] on_q, on_d, off_q, off_d;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Lamp on and off run lengths while the checksum fault is shown.
    assign on_d = (program_checksum_fault && error_lamp) ? on_q + 32'h1 : 32'h0;
    assign off_d = (program_checksum_fault && !error_lamp) ? off_q + 32'h1 : 32'h0;
    always_ff @(posedge clk) begin
        on_q <= rst ? 32'h0 : on_d;
        off_q <= rst ? 32'h0 : off_d;
    end
    // A live flag read under steady conditions while running.
    sequence live_read_s;
        system_run && !$past(rst) && reg_rd && reg_addr == `EMB_REG_LIVE && $stable(err_cond);
    endsequence
    boot_stays_off_a: assert property ($fell(rst) |-> !system_run)
        else $error("system runs at boot start");
    run_holds_a: assert property (system_run |=> system_run)
        else $error("system left run without reset");
    boot_quiet_a: assert property (!system_run && !program_checksum_fault
        && !watchdog_trip_fault |-> !serial_accept) else $error("serial open in boot tests");
    run_serial_a: assert property ($rose(system_run) |-> ##[0:1] serial_accept)
        else $error("serial closed while running");
    fault_halts_a: assert property ($rose(program_checksum_fault)
        |-> !system_run ##1 serial_accept[*8]) else $error("checksum fault not held in boot");
    steady_lamp_a: assert property (error_lamp && !serial_accept |=> error_lamp)
        else $error("halt lamp not steady");
    flash_on_a: assert property (on_q <= OnMax)
        else $error("flash pulse too long");
    flash_gap_a: assert property (off_q <= GapMax)
        else $error("flash gap too long");
    live_flag_a: assert property (live_read_s |=>
        (reg_rdata[15:0] & $past(err_cond)) == $past(err_cond)) else $error("live flag missing");
endmodule : emb_check_monitor
bind emb_monitor emb_check_monitor #(.CLK_KHZ(CLK_KHZ)) u_check (.*);
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "emb_regs.svh"
module testbench;
    import emb_pkg::*;
    localparam int Limit = 30000;
    // Count base shrunk to 2 kHz so that every long count but the hour count stays short.
    localparam int Khz = 2;
    localparam int Drop = `EMB_ALARM_DROP_MS * Khz;
    localparam int Boot = `EMB_BOOT_MS * Khz;
    localparam int Second = `EMB_SECOND_MS * Khz;
    logic clk = 1'b0, rst = 1'b1, watchdog_ok = 1'b1, watchdog_tripped = 1'b0;
    logic error_clear_switch = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tool_id_valid;
    emb_err_type err_cond = 16'h0000;
    logic [15:0] env_value [`EMB_NENV], setpoint = 16'h0000, tool_id;
    logic [15:0] boot_sum = 16'h1234, boot_sum_ref = 16'h1234;
    logic [15:0] prog_sum = 16'h5678, prog_sum_ref = 16'h5678;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic any_error_indicator, fatal_error_indicator, error_lamp, system_run;
    logic serial_accept, program_checksum_fault, watchdog_trip_fault;
    int err_total = 0, checks_done = 0, cyc = 0;
    emb_monitor #(.CLK_KHZ(Khz)) u_dut (.*);
    emb_tool_model u_tool (.*);
    // Clock and run-time ceiling.
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == Limit) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(what, exp, reg_rdata);
        @(posedge clk);
    endtask : rd_chk
    task automatic boot(output int n);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        n = 0;
        while (system_run !== 1'b1 && n < 3 * Boot) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
    endtask : boot
    task automatic drop_len(output int n);
        n = 0;
        repeat (4) if (any_error_indicator !== 1'b0) @(negedge clk);
        while (any_error_indicator === 1'b0 && n < 2 * Drop) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
    endtask : drop_len
    task automatic t_live();
        wr(`EMB_REG_CTRL, 32'h20);
        wr(`EMB_REG_FATAL_MASK, 32'h2);
        wr(`EMB_REG_AUTO_MASK, 32'h4);
        err_cond <= 16'h0007;
        repeat (3) @(negedge clk);
        chk("common alarm", 1, 32'(any_error_indicator));
        chk("fatal alarm", 1, 32'(fatal_error_indicator));
        @(posedge clk);
        rd_chk("live flags", `EMB_REG_LIVE, 32'h7);
        err_cond <= 16'h0001;
        repeat (3) @(posedge clk);
        rd_chk("self clear", `EMB_REG_LIVE, 32'h3);
        wr(`EMB_REG_CTRL, 32'h10);
        rd_chk("host clear", `EMB_REG_LIVE, 32'h1);
        @(negedge clk);
        chk("fatal gone", 0, 32'(fatal_error_indicator));
        @(posedge clk);
        err_cond <= 16'h0000;
        wr(`EMB_REG_CTRL, 32'h8);
        error_clear_switch <= 1'b1;
        repeat (6) @(posedge clk);
        error_clear_switch <= 1'b0;
        rd_chk("switch clear", `EMB_REG_LIVE, 32'h0);
        $display("test live flags done");
    endtask : t_live
    task automatic t_pulse();
        int n;
        wr(`EMB_REG_CTRL, 32'h3);
        err_cond <= 16'h0009;
        drop_len(n);
        chk("new drop", 1, 32'(n > Drop - 3 && n < Drop + 3));
        err_cond <= 16'h0001;
        wr(`EMB_REG_CTRL, 32'h13);
        drop_len(n);
        chk("clear drop", 1, 32'(n > Drop - 3 && n < Drop + 3));
        wr(`EMB_REG_CTRL, 32'h0);
        $display("test alarm pulses done");
    endtask : t_pulse
    task automatic t_hist();
        wr(`EMB_REG_ENV_SEL, 32'h0);
        rd_chk("count err3", `EMB_REG_HIST_BASE + 8'h3, 32'h1);
        rd_chk("count err4", `EMB_REG_HIST_BASE + 8'h4, 32'h0);
        wr(`EMB_REG_CTRL, 32'h20);
        rd_chk("cleared err3", `EMB_REG_HIST_BASE + 8'h3, 32'h0);
        env_value[0] <= 16'h00C4;
        err_cond <= 16'h0021;
        repeat (3) @(posedge clk);
        rd_chk("count err5", `EMB_REG_HIST_BASE + 8'h5, 32'h1);
        wr(`EMB_REG_ENV_SEL, 32'h3);
        rd_chk("env err5", `EMB_REG_HIST_BASE + 8'h5, 32'h00C4);
        wr(`EMB_REG_CTRL, 32'h4);
        wr(`EMB_REG_CTRL, 32'h24);
        err_cond <= 16'h0041;
        wr(`EMB_REG_ENV_SEL, 32'h0);
        rd_chk("inhibited err6", `EMB_REG_HIST_BASE + 8'h6, 32'h0);
        $display("test history done");
    endtask : t_hist
    task automatic t_time_id();
        rd_chk("idle seconds", `EMB_REG_SECONDS, 32'h0);
        setpoint <= 16'h0001;
        repeat (Second + 5) @(posedge clk);
        rd_chk("run seconds", `EMB_REG_SECONDS, 32'h1);
        u_tool.send_id(16'h3C5A);
        rd_chk("tool id", `EMB_REG_TOOL_ID, 32'h3C5A);
        wr(`EMB_REG_CTRL, 32'h40);
        rd_chk("saving id", `EMB_REG_LAST_ID, 32'h3C5A);
        $display("test run time and ids done");
    endtask : t_time_id
    task automatic t_fault(input string what, input logic [3:0] cfg, input logic [4:0] exp);
        int n;
        {watchdog_ok, watchdog_tripped} <= cfg[3:2];
        boot_sum <= cfg[1] ? 16'hFFFF : boot_sum_ref;
        prog_sum <= cfg[0] ? 16'hFFFF : prog_sum_ref;
        boot(n);
        repeat (1500) @(posedge clk);
        @(negedge clk);
        chk(what, 32'(exp), 32'({system_run, serial_accept, program_checksum_fault,
            watchdog_trip_fault, error_lamp | serial_accept}));
        @(posedge clk);
        $display("test boot fault done");
    endtask : t_fault
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    // Main sequence.
    initial begin
        int n;
        foreach (env_value[i]) env_value[i] = 16'h0000;
        boot(n);
        chk("boot time", 1, 32'(n >= Boot && n <= Boot + 4));
        chk("running", 1, 32'(system_run));
        chk("serial open", 1, 32'(serial_accept));
        t_live();
        t_pulse();
        t_hist();
        t_time_id();
        t_fault("watchdog fail", 4'b0000, 5'b00001);
        t_fault("boot sum", 4'b1010, 5'b00001);
        t_fault("prog sum", 4'b1001, 5'b01101);
        t_fault("watchdog trip", 4'b1100, 5'b01011);
        t_fault("test order", 4'b1011, 5'b00001);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
